/* autoneg_consts.vh */
// Purpose: Offsets, field positions, reset values for the negotiation status bank
// Assumes: Included by the bank and nothing else defines these names
// Notes:   Register indices times four give the byte offset inside a port window
`ifndef AUTONEG_CONSTS_VH
`define AUTONEG_CONSTS_VH

// Per-port window: byte address = port * 64 + index * 4
`define PORT_SHIFT        6
`define IDX_LSB           2
`define IDX_W             4
// Port window 0 holds the interrupt registers
`define IDX_IRQ_STATUS    4'h0
`define IDX_IRQ_MASK      4'h1
// Per-port registers sit at their PHY register numbers
`define IDX_LP_ABILITY    4'h5
`define IDX_EXP_STATUS    4'h6
`define IDX_NP_TRANSMIT   4'h7

// Partner base page ability fields
`define LP_NEXT_PAGE_BIT  15
`define LP_ACK_BIT        14
`define LP_FAULT_BIT      13
`define LP_RSVD_BIT       12
`define LP_PAUSE_MSB      11
`define LP_SELECTOR_MSB   4
`define LP_SELECTOR_IEEE  5'h01

// Expansion status fields
`define EXP_RSVD_W        11
`define EXP_PD_FAULT_BIT  4
`define EXP_LP_NP_BIT     3
`define EXP_NP_ABLE_BIT   2
`define EXP_PAGE_RX_BIT   1
`define EXP_LP_AN_BIT     0
`define EXP_NP_ABLE_RST   1'b1

// Next page transmit fields
`define NP_TOGGLE_BIT     11
`define NP_WR_MASK        16'hb7ff
`define NP_RST            16'h2001

// Interrupt events per port
`define IRQ_EV_PER_PORT   3
`define IRQ_EV_BASE_PAGE  0
`define IRQ_EV_PAGE_RX    1
`define IRQ_EV_PD_FAULT   2

`endif

/* latch_high_bit.v */
// Purpose: One sticky status bit, set by a condition, cleared by a strobe
// Assumes: Condition and clear are synchronous to hclk
// Notes:   A set in the clearing cycle wins, so no event is lost
`timescale 1ns/1ps

module latch_high_bit (
	input  wire hclk,
	input  wire hresetn,
	input  wire ce,
	input  wire cond,
	input  wire clr,
	output wire q
);

	reg  bit_q;
	wire bit_d;

	// Condition still present keeps the bit set through a clear
	assign bit_d = cond | (bit_q & ~clr);
	assign q     = bit_q;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bit_q <= 1'b0;
		end else if (ce) begin
			bit_q <= bit_d;
		end
	end

endmodule // latch_high_bit

/* autoneg_partner_status_regs.v */
// Purpose: Per-port partner ability, expansion status and next page transmit registers
// Assumes: Negotiation engine drives page events synchronous to hclk
// Notes:   AHB-Lite slave; reads take one wait state, writes none
`timescale 1ns/1ps
`include "autoneg_consts.vh"

// Notes on behaviour
// - Partner ability word, selector in bits 4:0
// - Bit 14 set once partner word received
// - Bit 13 reports partner remote fault
// - Bits 11:10 give partner pause ability
// - Bits 9:5 report partner technology modes
// - Expansion bit 4 latches parallel detection fault
// - Expansion bit 3 shows partner next page ability
// - Expansion bit 2 constant one, local next page
// - Expansion bit 1 latches new page received
// - Expansion bit 0 shows partner negotiation ability
// - Next page bit 15 writable, reset zero
// - Bit 13 message page reset one; message 0x001
// - Bit 12 writable comply flag, reset zero
// - Bit 11 read-only toggle of previous word
module autoneg_partner_status_regs #(
	parameter NUM_PORTS = 5,
	parameter AW        = 12
) (
	input  wire                    hclk,
	input  wire                    hresetn,
	input  wire                    ce,
	input  wire                    hsel,
	input  wire [AW-1:0]           haddr,
	input  wire [1:0]              htrans,
	input  wire                    hwrite,
	input  wire [2:0]              hsize,
	input  wire [31:0]             hwdata,
	input  wire                    hready,
	output wire [31:0]             hrdata,
	output wire                    hreadyout,
	output wire                    hresp,
	input  wire [NUM_PORTS-1:0]    lp_page_load,
	input  wire [16*NUM_PORTS-1:0] lp_page_word,
	input  wire [NUM_PORTS-1:0]    lp_an_able,
	input  wire [NUM_PORTS-1:0]    par_fault,
	input  wire [NUM_PORTS-1:0]    page_rcvd,
	input  wire [NUM_PORTS-1:0]    np_toggle_load,
	input  wire [NUM_PORTS-1:0]    np_toggle_value,
	output wire [16*NUM_PORTS-1:0] np_tx_word,
	output wire                    irq
);

	localparam NEV = `IRQ_EV_PER_PORT * NUM_PORTS;

	localparam [1:0] ST_IDLE = 2'd0;
	localparam [1:0] ST_WR   = 2'd1;
	localparam [1:0] ST_RD1  = 2'd2;
	localparam [1:0] ST_RD2  = 2'd3;

	reg  [1:0]             st_q;
	reg  [1:0]             st_d;
	reg  [2:0]             port_q;
	reg  [`IDX_W-1:0]      idx_q;
	reg  [31:0]            hrdata_q;
	reg  [31:0]            rd_d;
	reg  [NEV-1:0]         irq_mask_q;
	wire [NEV-1:0]         irq_stat;
	wire [16*NUM_PORTS-1:0] lp_rd;
	wire [16*NUM_PORTS-1:0] exp_rd;
	wire [16*NUM_PORTS-1:0] np_rd;
	wire                   accept;
	wire                   wr_en;
	wire                   rd_en;
	wire                   own_win;
	wire                   port_ok;
	wire [2:0]             port_idx;
	wire [6:0]             port_base;

	// Bus side
	assign accept    = ce & hsel & htrans[1] & hready;
	// Read data is built in the first data cycle so a write just before lands first
	assign hreadyout = ce & (st_q != ST_RD1);
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;
	assign wr_en     = ce & (st_q == ST_WR);
	assign rd_en     = ce & (st_q == ST_RD1);
	assign own_win   = (port_q == 3'd0);
	assign port_ok   = (port_q != 3'd0) && ({29'd0, port_q} <= NUM_PORTS);
	assign port_idx  = port_q - 3'd1;
	assign port_base = {port_idx, 4'b0000};

	always @* begin
		st_d = ST_IDLE;
		case (st_q)
			ST_RD1: begin
				st_d = ST_RD2;
			end
			ST_IDLE, ST_WR, ST_RD2: begin
				if (accept) begin
					st_d = hwrite ? ST_WR : ST_RD1;
				end else begin
					st_d = ST_IDLE;
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q   <= ST_IDLE;
			port_q <= 3'd0;
			idx_q  <= {`IDX_W{1'b0}};
		end else if (ce) begin
			st_q <= st_d;
			if (accept) begin
				port_q <= haddr[`PORT_SHIFT+2:`PORT_SHIFT];
				idx_q  <= haddr[`IDX_LSB+`IDX_W-1:`IDX_LSB];
			end
		end
	end

	// Per-port register bank
	genvar p;
	genvar k;
	generate
		for (p = 0; p < NUM_PORTS; p = p + 1) begin : g_port
			reg  [15:0] lp_word_q;
			reg         lp_rcvd_q;
			reg  [15:0] np_q;
			reg         np_tog_q;
			wire        sel;
			wire        exp_rd_clr;
			wire        pd_fault_lh;
			wire        page_rx_lh;
			wire [`IRQ_EV_PER_PORT-1:0] ev;

			assign sel        = (port_q == p + 1);
			assign exp_rd_clr = rd_en & sel & (idx_q == `IDX_EXP_STATUS);

			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					lp_word_q <= 16'h0000;
					lp_rcvd_q <= 1'b0;
				end else if (ce && lp_page_load[p]) begin
					lp_word_q <= lp_page_word[16*p +: 16];
					lp_rcvd_q <= 1'b1;
				end
			end

			// Selector, fault, pause and technology bits pass as the partner sent them
			assign lp_rd[16*p +: 16] = {lp_word_q[`LP_NEXT_PAGE_BIT],
				lp_rcvd_q,
				lp_word_q[`LP_FAULT_BIT],
				1'b0,
				lp_word_q[`LP_PAUSE_MSB:`LP_PAUSE_MSB-1],
				lp_word_q[9:5],
				lp_word_q[`LP_SELECTOR_MSB:0]};

			latch_high_bit u_pd_fault (
				.hclk    (hclk),
				.hresetn (hresetn),
				.ce      (ce),
				.cond    (par_fault[p]),
				.clr     (exp_rd_clr),
				.q       (pd_fault_lh)
			);

			latch_high_bit u_page_rx (
				.hclk    (hclk),
				.hresetn (hresetn),
				.ce      (ce),
				.cond    (page_rcvd[p]),
				.clr     (exp_rd_clr),
				.q       (page_rx_lh)
			);

			assign exp_rd[16*p +: 16] = {{`EXP_RSVD_W{1'b0}},
				pd_fault_lh,
				lp_word_q[`LP_NEXT_PAGE_BIT],
				`EXP_NP_ABLE_RST,
				page_rx_lh,
				lp_an_able[p]};

			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					np_q     <= `NP_RST;
					np_tog_q <= 1'b0;
				end else if (ce) begin
					if (wr_en && sel && idx_q == `IDX_NP_TRANSMIT) begin
						np_q <= hwdata[15:0] & `NP_WR_MASK;
					end
					if (np_toggle_load[p]) begin
						np_tog_q <= np_toggle_value[p];
					end
				end
			end

			// Toggle is never taken from software data
			assign np_rd[16*p +: 16] = (np_q & `NP_WR_MASK)
				| ({15'd0, np_tog_q} << `NP_TOGGLE_BIT);
			assign np_tx_word[16*p +: 16] = np_rd[16*p +: 16];

			// Interrupt events; a level fault keeps re-setting until it ends
			assign ev[`IRQ_EV_BASE_PAGE] = lp_page_load[p];
			assign ev[`IRQ_EV_PAGE_RX]   = page_rcvd[p];
			assign ev[`IRQ_EV_PD_FAULT]  = par_fault[p];

			for (k = 0; k < `IRQ_EV_PER_PORT; k = k + 1) begin : g_ev
				latch_high_bit u_stat (
					.hclk    (hclk),
					.hresetn (hresetn),
					.ce      (ce),
					.cond    (ev[k]),
					.clr     (wr_en & own_win & (idx_q == `IDX_IRQ_STATUS)
						& hwdata[`IRQ_EV_PER_PORT*p+k]),
					.q       (irq_stat[`IRQ_EV_PER_PORT*p+k])
				);
			end
		end
	endgenerate

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_mask_q <= {NEV{1'b0}};
		end else if (wr_en && own_win && idx_q == `IDX_IRQ_MASK) begin
			irq_mask_q <= hwdata[NEV-1:0];
		end
	end

	assign irq = |(irq_stat & irq_mask_q);

	// Read mux; unmapped words read zero
	always @* begin
		rd_d = 32'h0000_0000;
		if (own_win) begin
			case (idx_q)
				`IDX_IRQ_STATUS: begin
					rd_d[NEV-1:0] = irq_stat;
				end
				`IDX_IRQ_MASK: begin
					rd_d[NEV-1:0] = irq_mask_q;
				end
				default: begin
					rd_d = 32'h0000_0000;
				end
			endcase
		end else if (port_ok) begin
			case (idx_q)
				`IDX_LP_ABILITY: begin
					rd_d[15:0] = lp_rd[port_base +: 16];
				end
				`IDX_EXP_STATUS: begin
					rd_d[15:0] = exp_rd[port_base +: 16];
				end
				`IDX_NP_TRANSMIT: begin
					rd_d[15:0] = np_rd[port_base +: 16];
				end
				default: begin
					rd_d = 32'h0000_0000;
				end
			endcase
		end
	end

	// Value captured before the clear-on-read takes effect
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h0000_0000;
		end else if (rd_en) begin
			hrdata_q <= rd_d;
		end
	end

endmodule // autoneg_partner_status_regs

/* autoneg_status_chk_chk.sv */
// Purpose: Bus timing and next page word checks for the negotiation status bank
// Assumes: ce stays high while a transfer is open
// Notes:   Next page write and toggle checks watch port 1; the other ports share the same logic
`timescale 1ns/1ps

module autoneg_status_chk #(
	parameter NUM_PORTS = 5,
	parameter AW        = 12
) (
	input wire                    hclk,
	input wire                    hresetn,
	input wire                    ce,
	input wire                    hsel,
	input wire [AW-1:0]           haddr,
	input wire [1:0]              htrans,
	input wire                    hwrite,
	input wire [31:0]             hwdata,
	input wire                    hready,
	input wire [31:0]             hrdata,
	input wire                    hreadyout,
	input wire                    hresp,
	input wire [NUM_PORTS-1:0]    np_toggle_load,
	input wire [NUM_PORTS-1:0]    np_toggle_value,
	input wire [16*NUM_PORTS-1:0] np_tx_word,
	input wire                    irq
);
	reg  wr_np_q;
	wire taken = ce && hsel && htrans[1] && hready;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Marks the data phase of a write to the port 1 next page word
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			wr_np_q <= 1'b0;
		else if (ce && hready)
			wr_np_q <= taken && hwrite && haddr == 12'h05c;
	end
	property p_okay; hresp == 1'b0; endproperty
	a_okay: assert property (p_okay) else $error("response not okay");
	property p_upper; hrdata[31:16] == 16'h0000; endproperty
	a_upper: assert property (p_upper) else $error("upper read half not zero");
	property p_rd_wait; taken && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
	property p_wr_go; taken && hwrite |=> hreadyout; endproperty
	a_wr_go: assert property (p_wr_go) else $error("write stalled");
	property p_np_rst; $rose(hresetn) |-> np_tx_word == {NUM_PORTS{16'h2001}}; endproperty
	a_np_rst: assert property (p_np_rst) else $error("next page reset value");
	property p_np_wr;
		wr_np_q |=> (np_tx_word[15:0] & 16'hb7ff) == ($past(hwdata[15:0]) & 16'hb7ff);
	endproperty
	a_np_wr: assert property (p_np_wr) else $error("next page write lost");
	property p_tgl; ce && np_toggle_load[0] |=> np_tx_word[11] == $past(np_toggle_value[0]);
	endproperty
	a_tgl: assert property (p_tgl) else $error("toggle not loaded");
	property p_tgl_ro; wr_np_q && !np_toggle_load[0] |=> $stable(np_tx_word[11]); endproperty
	a_tgl_ro: assert property (p_tgl_ro) else $error("toggle written by bus");
	c_irq: cover property (irq);
	c_np_wr: cover property (wr_np_q);
	c_tgl: cover property (np_toggle_load[0]);
endmodule // autoneg_status_chk

/* test_autoneg_partner_status_regs.sv */
// Purpose: Bus level test of the negotiation status bank
// Assumes: Single slave, hready taken from hreadyout
// Notes:   Ports 1-4 get partner words; port 1 also gets the status events
`timescale 1ns/1ps

module test_autoneg_partner_status_regs;
	reg         hclk = 1'b0;
	reg         hresetn = 1'b0;
	reg         ce = 1'b1;
	reg         hsel = 1'b0;
	reg  [11:0] haddr = 12'h000;
	reg  [1:0]  htrans = 2'h0;
	reg         hwrite = 1'b0;
	reg  [31:0] hwdata = 32'h0000_0000;
	reg  [4:0]  lp_page_load = 5'h00, lp_an_able = 5'h00, par_fault = 5'h00;
	reg  [4:0]  page_rcvd = 5'h00, np_toggle_load = 5'h00, np_toggle_value = 5'h00;
	reg  [79:0] lp_page_word = 80'h0;
	wire [31:0] hrdata;
	wire        hreadyout, hresp, irq;
	wire [79:0] np_tx_word;
	integer     fails = 0, tests_run = 0, k;
	reg  [31:0] d;
	reg  [15:0] w;
	always #2.5 hclk = ~hclk;
	autoneg_partner_status_regs dut_u (
		.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.lp_page_load(lp_page_load), .lp_page_word(lp_page_word), .lp_an_able(lp_an_able),
		.par_fault(par_fault), .page_rcvd(page_rcvd), .np_toggle_load(np_toggle_load),
		.np_toggle_value(np_toggle_value), .np_tx_word(np_tx_word), .irq(irq)
	);
	task end_sim;
		$display("Checks %0d, errors %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		tests_run = tests_run + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("ERROR %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// No wait count is assumed; only the watchdog ends a stuck transfer
	task xfer(input wr, input [11:0] a, input [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		d = hrdata;
	endtask
	task rc(input [11:0] a, input [31:0] exp);
		xfer(1'b0, a, 32'h0000_0000);
		chk(d, exp);
	endtask
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		rc(12'h05c, 32'h0000_2001);
		rc(12'h058, 32'h0000_0004);
		rc(12'h054, 32'h0000_0000);
		for (k = 0; k < 4; k = k + 1) begin
			// Technology bits alternate so a stuck bit in 9:5 shows up
			w = {k[0], 1'b0, k[1], 1'b1, k[1:0], {5{k[0]}} ^ 5'h0a, 5'h01};
			@(posedge hclk);
			lp_page_word[16*k +: 16] <= w;
			lp_page_load[k] <= 1'b1;
			@(posedge hclk);
			lp_page_load <= 5'h00;
			rc(12'h054 + 64 * k, w ^ 16'h5000);
			rc(12'h058 + 64 * k, {k[0], 3'h4});
		end
		chk(irq, 1'b0);
		lp_an_able <= 5'h01;
		par_fault <= 5'h01;
		page_rcvd <= 5'h01;
		@(posedge hclk);
		par_fault <= 5'h00;
		page_rcvd <= 5'h00;
		rc(12'h058, 32'h0000_0017);
		rc(12'h058, 32'h0000_0005);
		par_fault <= 5'h01;
		rc(12'h058, 32'h0000_0015);
		rc(12'h058, 32'h0000_0015);
		par_fault <= 5'h00;
		xfer(1'b1, 12'h004, 32'h0000_7fff);
		@(negedge hclk);
		chk(irq, 1'b1);
		rc(12'h000, 32'h0000_024f);
		xfer(1'b1, 12'h000, 32'h0000_7fff);
		rc(12'h000, 32'h0000_0000);
		@(negedge hclk);
		chk(irq, 1'b0);
		@(posedge hclk);
		page_rcvd <= 5'h01;
		@(posedge hclk);
		page_rcvd <= 5'h00;
		repeat (2) @(posedge hclk);
		@(negedge hclk);
		chk(irq, 1'b1);
		xfer(1'b1, 12'h05c, 32'h0000_ffff);
		@(negedge hclk);
		chk(np_tx_word[15:0], 16'hb7ff);
		rc(12'h05c, 32'h0000_b7ff);
		np_toggle_value <= 5'h01;
		np_toggle_load <= 5'h01;
		@(posedge hclk);
		np_toggle_load <= 5'h00;
		rc(12'h05c, 32'h0000_bfff);
		xfer(1'b1, 12'h05c, 32'h0000_0000);
		rc(12'h05c, 32'h0000_0800);
		// Unmapped slot: write dropped, read zero
		xfer(1'b1, 12'h0fc, 32'h0000_ffff);
		rc(12'h0fc, 32'h0000_0000);
		end_sim;
	end
	initial begin
		#20000;
		fails = fails + 1;
		end_sim;
	end
endmodule // test_autoneg_partner_status_regs

bind autoneg_partner_status_regs autoneg_status_chk #(.NUM_PORTS(NUM_PORTS), .AW(AW)) chk_u (
	.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
	.np_toggle_load(np_toggle_load), .np_toggle_value(np_toggle_value),
	.np_tx_word(np_tx_word)
);
